//--- sfscr_pkg.sv
/*
  Shared types and constants for the flash status and configuration
  register set: command codes, register layouts, reset values, timing.
  Assumes a 125 MHz system clock and a command decoder in front.
*/
`default_nettype none

package sfscr_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int REG_WRITE_NS = 200;
  localparam int REG_WRITE_CYCLES = (REG_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Field positions and sizes
  // ----------------------------------------
  localparam int SECTOR_MSB = 25;
  localparam int SECTOR_LSB = 18;
  localparam int BANK_BIT_POS = 1;
  localparam int LONG_ADDR_POS = 7;
  localparam int SHORT_ADDR_MSB = 23;
  localparam logic [8:0] MIN_PROT_SECTORS = 9'h004;
  localparam logic [8:0] ALL_SECTORS = 9'h100;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [2:0] RANGE_VOLATILE_RESET = 3'h7;
  localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
  localparam logic [7:0] UPPER_PAGE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_WRITE_ENABLE,
    CMD_WRITE_DISABLE,
    CMD_REG_WRITE,
    CMD_BANK_WRITE,
    CMD_PROGRAM,
    CMD_ERASE,
    CMD_SUSPEND,
    CMD_RESUME
  } sfscr_cmd_type;

  typedef struct packed {
    logic [7:0] statusByte;
    logic [7:0] configByte;
    logic configPresent;
  } sfscr_reg_write_type;

  typedef struct packed {
    logic lock;
    logic [2:0] range;
    logic [1:0] latency;
    logic origin;
    logic volatility;
    logic quad;
  } sfscr_nv_type;

endpackage

`default_nettype wire

//--- sfscr_protect_range.sv
/*
  Decides whether an address falls in the protected sector range.
  Assumes 256 sectors of 256 kbyte in a 64 Mbyte array.
*/
`timescale 1ns/1ps
`default_nettype none

module sfscr_protect_range (
  // Protection setting
  input wire logic [2:0] rangeCode,
  input wire logic fromBottom,
  // Address under test
  input wire logic [31:0] address,
  // Verdict
  output logic hit
);

  logic [8:0] sector;
  logic [8:0] count;

  // ----------------------------------------
  // Range decode
  // ----------------------------------------
  always_comb begin
    sector = {1'b0, address[sfscr_pkg::SECTOR_MSB:sfscr_pkg::SECTOR_LSB]};
    if (rangeCode == 3'h0) begin
      count = 9'h000;
    end else if (rangeCode == 3'h7) begin
      count = sfscr_pkg::ALL_SECTORS;
    end else begin
      count = sfscr_pkg::MIN_PROT_SECTORS << (rangeCode - 3'h1); // [R04]
    end
    if (fromBottom) begin
      hit = sector < count; // [R11]
    end else begin
      hit = sector >= (sfscr_pkg::ALL_SECTORS - count); // [R11]
    end
  end

endmodule

`default_nettype wire

//--- sfscr_regs.sv
/*
  Status, configuration, second status and upper address page registers
  of a serial NOR flash, with the command gating they impose.
  Assumes a decoder that delivers one decoded command per valid pulse,
  an array core that runs program and erase, and a non-volatile store
  that presents its image while nrst is low.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01: Lock bit set with write-protect pin low makes register writes ignored.
// R02: Programming error flag is set when a program fails, else zero.
// R03: Erase error flag is set when an erase fails, else zero.
// R04: Three range bits pick a sector range safe from program and erase.
// R05: One-time volatility bit makes the range bits volatile or non-volatile.
// R06: Write enable latch gates register write, program and erase commands.
// R07: Only write enable and write disable commands change the latch.
// R08: Busy flag is one while any internal operation runs.
// R09: Idle device reports not busy and accepts new commands.
// R10: Two non-volatile bits form the read latency code, default zero.
// R11: One-time origin bit puts protection at low addresses when one.
// R12: Non-volatile quad bit enables four-line data operation.
// R13: Freeze bit locks range bits and origin bit.
// R14: Erase suspend flag reads one while an erase is suspended.
// R15: Program suspend flag reads one while a program is suspended.
// R16: Long address mode makes each addressed command carry 32 address bits.
// R17: Short mode takes 24 command bits plus upper bits from the page.
// R18: Page bit one supplies address bit 25; all page bits reset zero.
// R19: Reserved bits of second status and page registers read zero.
module sfscr_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Write protect pin
  input wire logic wpN,
  // Decoded commands
  input wire logic cmdValid,
  input wire sfscr_pkg::sfscr_cmd_type cmdCode,
  input wire sfscr_pkg::sfscr_reg_write_type cmdWrite,
  input wire logic [7:0] cmdBank,
  input wire logic [31:0] cmdAddr,
  output logic cmdRefused,
  // Array core
  output logic coreStart,
  output logic coreErase,
  output logic [31:0] coreAddr,
  output logic coreSuspend,
  output logic coreResume,
  input wire logic coreDone,
  input wire logic coreFail,
  // Non-volatile store
  input wire sfscr_pkg::sfscr_nv_type nvLoad,
  output sfscr_pkg::sfscr_nv_type nvStore,
  output logic nvCommit,
  // Register views
  output logic [7:0] statusOne,
  output logic [7:0] configOne,
  output logic [7:0] statusTwo,
  output logic [7:0] upperAddressPage,
  // Mode outputs
  output logic quadEnable,
  output logic [1:0] latencyCode
);

  typedef enum logic [1:0] {ST_IDLE, ST_REG_WRITE, ST_ARRAY} sfscr_state_type;

  sfscr_state_type state, next_state;
  logic [7:0] waitCount, next_waitCount;
  logic [2:0] range, next_range;
  logic lockBit, next_lockBit, progErr, next_progErr, eraseErr, next_eraseErr, write_enable_latch, next_wel;
  logic origin, next_origin, volSel, next_volSel, freeze, next_freeze;
  logic eraseSusp, next_eraseSusp, progSusp, next_progSusp, longAddr, next_longAddr;
  logic bankBit, next_bankBit, next_quadEnable;
  logic [1:0] next_latencyCode;
  logic next_cmdRefused, next_coreStart, next_coreErase;
  logic [31:0] next_coreAddr;
  logic next_coreSuspend, next_coreResume, next_nvCommit;
  sfscr_pkg::sfscr_nv_type next_nvStore;
  logic [7:0] next_statusOne, next_configOne, next_statusTwo, next_upperAddressPage;

  logic idle, regLocked, suspended, protHit;
  logic [31:0] addrFull;

  // ----------------------------------------
  // Address forming and protection check
  // ----------------------------------------
  assign idle = (state == ST_IDLE);
  assign regLocked = lockBit & ~wpN; // [R01]
  assign suspended = eraseSusp | progSusp;
  // Bit 24 follows the reserved page bit, which always reads zero
  assign addrFull = longAddr ? cmdAddr // [R16]
                  : {6'h00, bankBit, 1'b0, cmdAddr[sfscr_pkg::SHORT_ADDR_MSB:0]}; // [R17] [R18]

  sfscr_protect_range u_protect (
    .rangeCode(range),
    .fromBottom(origin),
    .address(addrFull),
    .hit(protHit)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_waitCount = waitCount;
    next_lockBit = lockBit;
    next_range = range;
    next_progErr = progErr;
    next_eraseErr = eraseErr;
    next_wel = write_enable_latch;
    next_origin = origin;
    next_volSel = volSel;
    next_freeze = freeze;
    next_eraseSusp = eraseSusp;
    next_progSusp = progSusp;
    next_longAddr = longAddr;
    next_bankBit = bankBit;
    next_quadEnable = quadEnable;
    next_latencyCode = latencyCode;
    next_cmdRefused = 1'b0;
    next_coreStart = 1'b0;
    next_coreErase = coreErase;
    next_coreAddr = coreAddr;
    next_coreSuspend = 1'b0;
    next_coreResume = 1'b0;
    next_nvCommit = 1'b0;
    next_nvStore = nvStore;
    unique case (state)
      ST_IDLE: begin
        if (cmdValid) begin // [R09]
          unique case (cmdCode)
            sfscr_pkg::CMD_WRITE_ENABLE: begin
              next_wel = 1'b1; // [R07]
            end
            sfscr_pkg::CMD_WRITE_DISABLE: begin
              next_wel = 1'b0; // [R07]
            end
            sfscr_pkg::CMD_REG_WRITE: begin
              if (write_enable_latch && !regLocked) begin // [R06] [R01]
                next_lockBit = cmdWrite.statusByte[7];
                if (!freeze) begin
                  next_range = cmdWrite.statusByte[4:2]; // [R13]
                end
                if (cmdWrite.configPresent) begin
                  next_latencyCode = cmdWrite.configByte[7:6]; // [R10]
                  next_quadEnable = cmdWrite.configByte[1]; // [R12]
                  // One-time bits can only go from zero to one
                  if (!freeze) begin
                    next_origin = origin | cmdWrite.configByte[5]; // [R11] [R13]
                  end
                  next_volSel = volSel | cmdWrite.configByte[3]; // [R05]
                  next_freeze = freeze | cmdWrite.configByte[0]; // [R13]
                end
                next_nvStore.lock = next_lockBit;
                next_nvStore.latency = next_latencyCode;
                next_nvStore.origin = next_origin;
                next_nvStore.volatility = next_volSel;
                next_nvStore.quad = next_quadEnable;
                if (!next_volSel) begin
                  next_nvStore.range = next_range; // [R05]
                end
                next_nvCommit = 1'b1;
                next_waitCount = 8'(sfscr_pkg::REG_WRITE_CYCLES);
                next_state = ST_REG_WRITE; // [R08]
              end else begin
                next_cmdRefused = 1'b1;
              end
            end
            sfscr_pkg::CMD_BANK_WRITE: begin
              next_longAddr = cmdBank[sfscr_pkg::LONG_ADDR_POS];
              next_bankBit = cmdBank[sfscr_pkg::BANK_BIT_POS]; // [R18] [R19]
            end
            sfscr_pkg::CMD_PROGRAM, sfscr_pkg::CMD_ERASE: begin
              if (!write_enable_latch || suspended) begin // [R06]
                next_cmdRefused = 1'b1;
              end else if (protHit) begin // [R04]
                // A protected target counts as a failed operation
                next_cmdRefused = 1'b1;
                if (cmdCode == sfscr_pkg::CMD_ERASE) begin
                  next_eraseErr = 1'b1; // [R03]
                end else begin
                  next_progErr = 1'b1; // [R02]
                end
              end else begin
                next_coreStart = 1'b1;
                next_coreErase = (cmdCode == sfscr_pkg::CMD_ERASE);
                next_coreAddr = addrFull;
                if (cmdCode == sfscr_pkg::CMD_ERASE) begin
                  next_eraseErr = 1'b0; // [R03]
                end else begin
                  next_progErr = 1'b0; // [R02]
                end
                next_state = ST_ARRAY; // [R08]
              end
            end
            sfscr_pkg::CMD_SUSPEND: begin
              next_cmdRefused = 1'b1;
            end
            sfscr_pkg::CMD_RESUME: begin
              if (suspended) begin
                next_coreResume = 1'b1;
                next_eraseSusp = 1'b0; // [R14]
                next_progSusp = 1'b0; // [R15]
                next_state = ST_ARRAY; // [R08]
              end else begin
                next_cmdRefused = 1'b1;
              end
            end
          endcase
        end
      end
      ST_REG_WRITE: begin
        next_cmdRefused = cmdValid;
        next_waitCount = waitCount - 8'h01;
        if (waitCount == 8'h01) begin
          next_state = ST_IDLE; // [R09]
        end
      end
      ST_ARRAY: begin
        // Completion wins over a suspend in the same cycle
        if (coreDone) begin
          if (coreFail && coreErase) begin
            next_eraseErr = 1'b1; // [R03]
          end else if (coreFail) begin
            next_progErr = 1'b1; // [R02]
          end
          next_state = ST_IDLE; // [R09]
        end else if (cmdValid && cmdCode == sfscr_pkg::CMD_SUSPEND) begin
          next_coreSuspend = 1'b1;
          next_eraseSusp = coreErase; // [R14]
          next_progSusp = ~coreErase; // [R15]
          next_state = ST_IDLE;
        end else begin
          next_cmdRefused = cmdValid;
        end
      end
    endcase
    next_statusOne = {next_lockBit, next_progErr, next_eraseErr, next_range, next_wel,
                      next_state != ST_IDLE}; // [R08] [R09]
    next_configOne = {next_latencyCode, next_origin, 1'b0, next_volSel, 1'b0, next_quadEnable, next_freeze};
    next_statusTwo = {6'h00, next_eraseSusp, next_progSusp}; // [R19]
    next_upperAddressPage = {next_longAddr, 5'h00, next_bankBit, 1'b0}; // [R19]
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      waitCount <= 8'h00;
      lockBit <= nvLoad.lock;
      range <= nvLoad.volatility ? sfscr_pkg::RANGE_VOLATILE_RESET : nvLoad.range; // [R05]
      progErr <= 1'b0;
      eraseErr <= 1'b0;
      write_enable_latch <= 1'b0;
      origin <= nvLoad.origin;
      volSel <= nvLoad.volatility;
      freeze <= 1'b0;
      eraseSusp <= 1'b0;
      progSusp <= 1'b0;
      longAddr <= 1'b0;
      bankBit <= 1'b0; // [R18]
      quadEnable <= nvLoad.quad;
      latencyCode <= nvLoad.latency;
      cmdRefused <= 1'b0;
      coreStart <= 1'b0;
      coreErase <= 1'b0;
      coreAddr <= 32'h00000000;
      coreSuspend <= 1'b0;
      coreResume <= 1'b0;
      nvCommit <= 1'b0;
      nvStore <= nvLoad;
      statusOne <= {nvLoad.lock, 2'h0, nvLoad.volatility ? sfscr_pkg::RANGE_VOLATILE_RESET : nvLoad.range, 2'h0};
      configOne <= {nvLoad.latency, nvLoad.origin, 1'b0, nvLoad.volatility, 1'b0, nvLoad.quad, 1'b0};
      statusTwo <= sfscr_pkg::STATUS_TWO_RESET;
      upperAddressPage <= sfscr_pkg::UPPER_PAGE_RESET;
    end else begin
      state <= next_state;
      waitCount <= next_waitCount;
      lockBit <= next_lockBit;
      range <= next_range;
      progErr <= next_progErr;
      eraseErr <= next_eraseErr;
      write_enable_latch <= next_wel;
      origin <= next_origin;
      volSel <= next_volSel;
      freeze <= next_freeze;
      eraseSusp <= next_eraseSusp;
      progSusp <= next_progSusp;
      longAddr <= next_longAddr;
      bankBit <= next_bankBit;
      quadEnable <= next_quadEnable;
      latencyCode <= next_latencyCode;
      cmdRefused <= next_cmdRefused;
      coreStart <= next_coreStart;
      coreErase <= next_coreErase;
      coreAddr <= next_coreAddr;
      coreSuspend <= next_coreSuspend;
      coreResume <= next_coreResume;
      nvCommit <= next_nvCommit;
      nvStore <= next_nvStore;
      statusOne <= next_statusOne;
      configOne <= next_configOne;
      statusTwo <= next_statusTwo;
      upperAddressPage <= next_upperAddressPage;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_lock_blocks_write: assert property ( // [R01]
    cmdValid && idle && cmdCode == sfscr_pkg::CMD_REG_WRITE && lockBit && !wpN
    |=> $stable(lockBit) && $stable(range) && !nvCommit && cmdRefused)
    else $error("register write taken while locked");
  a_prog_fail_flag: assert property ( // [R02]
    state == ST_ARRAY && coreDone && coreFail && !coreErase |=> progErr && statusOne[6])
    else $error("program failure not flagged");
  a_erase_fail_flag: assert property ( // [R03]
    state == ST_ARRAY && coreDone && coreFail && coreErase |=> eraseErr && statusOne[5])
    else $error("erase failure not flagged");
  a_protect_blocks_op: assert property ( // [R04]
    cmdValid && idle && cmdCode == sfscr_pkg::CMD_PROGRAM && write_enable_latch && !suspended && protHit
    |=> !coreStart && progErr)
    else $error("protected sector reached the core");
  a_start_needs_wel: assert property ( // [R06]
    coreStart |-> $past(write_enable_latch) && $past(idle))
    else $error("operation started without write enable");
  a_wel_only_cmds: assert property ( // [R07]
    $changed(write_enable_latch) |-> $past(cmdValid && idle
      && (cmdCode == sfscr_pkg::CMD_WRITE_ENABLE || cmdCode == sfscr_pkg::CMD_WRITE_DISABLE)))
    else $error("write enable latch changed by other command");
  a_busy_during_op: assert property ( // [R08]
    coreStart |-> statusOne[0] ##1 (statusOne[0] || $past(coreDone)))
    else $error("busy flag missing during operation");
  a_idle_not_busy: assert property ( // [R09]
    idle |-> !statusOne[0])
    else $error("idle device reports busy");
  a_freeze_holds_range: assert property ( // [R13]
    freeze |=> $stable(range) && $stable(origin) && freeze)
    else $error("frozen protection bits changed");
  a_erase_suspend_flag: assert property ( // [R14]
    state == ST_ARRAY && coreErase && !coreDone && cmdValid && cmdCode == sfscr_pkg::CMD_SUSPEND
    |=> eraseSusp && statusTwo[1] && coreSuspend && !statusOne[0])
    else $error("erase suspend not reported");
  a_short_addr_page: assert property ( // [R17]
    coreStart && !longAddr |-> coreAddr[31:24] == {6'h00, bankBit, 1'b0})
    else $error("upper address bits not from page");
  a_reserved_zero: assert property ( // [R19]
    statusTwo[7:2] == 6'h00 && upperAddressPage[6:2] == 5'h00 && !upperAddressPage[0])
    else $error("reserved bits not zero");

  c_reg_write: cover property (nvCommit ##1 statusOne[0]);
  c_program_done: cover property (coreStart && !coreErase ##[1:50] idle);
  c_erase_suspend: cover property (coreSuspend && eraseSusp ##[1:20] coreResume);

endmodule

`default_nettype wire

//--- sfscr_core_model.sv
/*
  Behavioural array core and non-volatile store facing the register set.
  Assumes one register set on the same sys_clk; the image survives nrst.
*/
`timescale 1ns/1ps
`default_nettype none

module sfscr_core_model #(
  parameter int DLY = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Core control
  input wire logic coreStart,
  input wire logic coreSuspend,
  input wire logic coreResume,
  input wire logic failNext,
  output logic coreDone,
  output logic coreFail,
  // Store
  input wire sfscr_pkg::sfscr_nv_type nvStore,
  input wire logic nvCommit,
  output sfscr_pkg::sfscr_nv_type nvLoad
);
  // ----------------------------------------
  // Array operation
  // ----------------------------------------
  logic running = 1'b0;
  int count = 0;
  sfscr_pkg::sfscr_nv_type image = '0;

  initial coreDone = 1'b0;
  initial coreFail = 1'b0;
  assign nvLoad = image;

  always @(posedge sys_clk) begin
    coreDone <= 1'b0;
    // Fail level toggles when not qualified by done
    coreFail <= ~coreFail;
    if (nvCommit) begin
      image <= nvStore;
    end
    if (!nrst) begin
      running <= 1'b0;
      count <= 0;
    end else if (coreStart) begin
      running <= 1'b1;
      count <= 0;
    end else if (coreSuspend) begin
      running <= 1'b0;
    end else if (coreResume) begin
      running <= 1'b1;
    end else if (running) begin
      if (count == DLY - 1) begin
        running <= 1'b0;
        coreDone <= 1'b1;
        coreFail <= failNext;
      end else begin
        count <= count + 1;
      end
    end
  end
endmodule

`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the flash status and configuration registers.
  Assumes the core model on the far side; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk, nrst, wpN, cmdValid, cmdRefused, refused, failNext;
  sfscr_pkg::sfscr_cmd_type cmdCode;
  sfscr_pkg::sfscr_reg_write_type cmdWrite;
  logic [7:0] cmdBank, statusOne, configOne, statusTwo, upperAddressPage;
  logic [31:0] cmdAddr, coreAddr;
  logic coreStart, coreErase, coreSuspend, coreResume, coreDone, coreFail, nvCommit, quadEnable;
  sfscr_pkg::sfscr_nv_type nvLoad, nvStore;
  logic [1:0] latencyCode;
  int errors, comparisons, busyN;

  sfscr_regs i_dut (.sys_clk(sys_clk), .nrst(nrst), .wpN(wpN), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdWrite(cmdWrite), .cmdBank(cmdBank), .cmdAddr(cmdAddr), .cmdRefused(cmdRefused),
    .coreStart(coreStart), .coreErase(coreErase), .coreAddr(coreAddr), .coreSuspend(coreSuspend),
    .coreResume(coreResume), .coreDone(coreDone), .coreFail(coreFail), .nvLoad(nvLoad),
    .nvStore(nvStore), .nvCommit(nvCommit), .statusOne(statusOne), .configOne(configOne),
    .statusTwo(statusTwo), .upperAddressPage(upperAddressPage), .quadEnable(quadEnable),
    .latencyCode(latencyCode));

  sfscr_core_model i_core (.sys_clk(sys_clk), .nrst(nrst), .coreStart(coreStart),
    .coreSuspend(coreSuspend), .coreResume(coreResume), .failNext(failNext), .coreDone(coreDone),
    .coreFail(coreFail), .nvStore(nvStore), .nvCommit(nvCommit), .nvLoad(nvLoad));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Refused pulse may land on the taking edge or one cycle after it
  task automatic issue(input sfscr_pkg::sfscr_cmd_type code, input logic [31:0] addr = 32'h0,
      input logic [7:0] stat = 8'h00, input logic [7:0] cfg = 8'h00, input logic on = 1'b0);
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdCode = code;
    cmdWrite = {stat, cfg, on};
    cmdBank = stat;
    cmdAddr = addr;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    refused = cmdRefused;
    busyN = statusOne[0];
    @(negedge sys_clk);
    refused = refused | cmdRefused;
    busyN += statusOne[0];
  endtask

  task automatic waitIdle;
    repeat (200) if (statusOne[0] === 1'b1) begin
      @(negedge sys_clk);
      busyN += statusOne[0];
    end
  endtask

  task automatic resetDut;
    nrst = 1'b0;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
  endtask

  task automatic conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tReset;
    chk("statusOneReset", 8'h00, statusOne);
    chk("configOneReset", 8'h00, configOne);
    chk("statusTwoReset", 8'h00, statusTwo);
    chk("pageReset", 8'h00, upperAddressPage);
  endtask

  task automatic tEnable;
    issue(sfscr_pkg::CMD_REG_WRITE, 0, 8'h0C);
    chk("refusedNoLatch", 1, refused);
    chk("statusNoLatch", 8'h00, statusOne);
    issue(sfscr_pkg::CMD_WRITE_ENABLE);
    chk("latchSet", 8'h02, statusOne);
    issue(sfscr_pkg::CMD_REG_WRITE, 0, 8'h0C);
    waitIdle();
    chk("busyCycles", sfscr_pkg::REG_WRITE_CYCLES, busyN);
    chk("statusWritten", 8'h0E, statusOne);
    issue(sfscr_pkg::CMD_WRITE_DISABLE);
    chk("latchClear", 8'h0C, statusOne);
    issue(sfscr_pkg::CMD_PROGRAM);
    chk("refusedProgram", 1, refused);
  endtask

  task automatic tLock;
    issue(sfscr_pkg::CMD_WRITE_ENABLE);
    issue(sfscr_pkg::CMD_REG_WRITE, 0, 8'h80);
    waitIdle();
    chk("lockSet", 8'h82, statusOne);
    wpN = 1'b0;
    issue(sfscr_pkg::CMD_REG_WRITE);
    chk("refusedLocked", 1, refused);
    chk("statusLocked", 8'h82, statusOne);
    wpN = 1'b1;
    issue(sfscr_pkg::CMD_REG_WRITE);
    waitIdle();
    chk("lockCleared", 8'h02, statusOne);
  endtask

  task automatic tErrors;
    for (int i = 0; i < 4; i++) begin
      failNext = (i == 0 || i == 2);
      issue((i < 2) ? sfscr_pkg::CMD_PROGRAM : sfscr_pkg::CMD_ERASE);
      chk("coreKind", i >= 2, coreErase);
      waitIdle();
      chk("errorFlags", {1'b0, i == 0, i == 2, 5'b00010}, statusOne);
    end
    failNext = 1'b0;
  endtask

  task automatic tSuspend;
    issue(sfscr_pkg::CMD_SUSPEND);
    chk("refusedIdleSuspend", 1, refused);
    for (int i = 0; i < 2; i++) begin
      issue(i ? sfscr_pkg::CMD_PROGRAM : sfscr_pkg::CMD_ERASE);
      issue(sfscr_pkg::CMD_SUSPEND);
      chk("suspendFlags", i ? 8'h01 : 8'h02, statusTwo);
      chk("suspendIdle", 0, statusOne[0]);
      issue(sfscr_pkg::CMD_RESUME);
      chk("resumedFlags", 8'h00, statusTwo);
      waitIdle();
    end
  endtask

  task automatic tAddress;
    issue(sfscr_pkg::CMD_BANK_WRITE, 0, 8'hFF);
    chk("pageReserved", 8'h82, upperAddressPage);
    issue(sfscr_pkg::CMD_BANK_WRITE, 0, 8'h02);
    chk("pageShort", 8'h02, upperAddressPage);
    issue(sfscr_pkg::CMD_PROGRAM, 32'hFF12_3456);
    chk("shortAddress", 32'h0212_3456, coreAddr);
    waitIdle();
    issue(sfscr_pkg::CMD_BANK_WRITE, 0, 8'h80);
    chk("pageLong", 8'h80, upperAddressPage);
    issue(sfscr_pkg::CMD_PROGRAM, 32'hFD12_3456);
    chk("longAddress", 32'hFD12_3456, coreAddr);
    waitIdle();
  endtask

  task automatic tConfig;
    issue(sfscr_pkg::CMD_REG_WRITE, 0, 8'h00, 8'hAA, 1'b1);
    waitIdle();
    chk("configWritten", 8'hAA, configOne);
    chk("modeOutputs", 3'b110, {quadEnable, latencyCode});
    resetDut();
    chk("volatileRange", 8'h1C, statusOne);
    chk("configKept", 8'hAA, configOne);
  endtask

  // Bottom origin with code one guards sectors zero to three
  task automatic tProtect;
    issue(sfscr_pkg::CMD_BANK_WRITE, 0, 8'h80);
    issue(sfscr_pkg::CMD_WRITE_ENABLE);
    issue(sfscr_pkg::CMD_REG_WRITE, 0, 8'h04);
    waitIdle();
    issue(sfscr_pkg::CMD_PROGRAM, 32'h0000_0000);
    chk("refusedProtected", 1, refused);
    chk("protectError", 8'h46, statusOne);
    issue(sfscr_pkg::CMD_PROGRAM, 32'h03FC_0000);
    chk("acceptedTop", 0, refused);
    waitIdle();
    chk("errorCleared", 8'h06, statusOne);
  endtask

  task automatic tFreeze;
    issue(sfscr_pkg::CMD_REG_WRITE, 0, 8'h04, 8'hAB, 1'b1);
    waitIdle();
    chk("freezeSet", 8'hAB, configOne);
    issue(sfscr_pkg::CMD_REG_WRITE, 0, 8'h10);
    waitIdle();
    chk("rangeFrozen", 3'b001, statusOne[4:2]);
  endtask

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    nrst = 1'b0;
    wpN = 1'b1;
    cmdValid = 1'b0;
    cmdCode = sfscr_pkg::CMD_WRITE_ENABLE;
    cmdWrite = '0;
    cmdBank = 8'h00;
    cmdAddr = 32'h0;
    failNext = 1'b0;
    refused = 1'b0;
    errors = 0;
    comparisons = 0;
    busyN = 0;
    resetDut();
    tReset();
    tEnable();
    tLock();
    tErrors();
    tSuspend();
    tAddress();
    tConfig();
    tProtect();
    tFreeze();
    conclude();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule

`default_nettype wire
